// File: rtl/dual_timer_consts.svh
// register offsets, field positions and timing counts of the dual timer
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH
`define TMR_ADDR_W        8
`define TMR_OFS_CTRL      8'h88
`define TMR_OFS_MODE      8'h89
`define TMR_OFS_T0L       8'h8A
`define TMR_OFS_T1L       8'h8B
`define TMR_OFS_T0H       8'h8C
`define TMR_OFS_T1H       8'h8D
`define TMR_OFS_CLKOPT    8'hCE
`define TMR_OFS_T2L       8'hCC
`define TMR_OFS_T2H       8'hCD
`define TMR_OFS_T2CTRL    8'hC8
`define TMR_OFS_IRQEN     8'hA8
`define TMR_RESET_VAL     8'h00
`define TMR_CLKOPT_MASK   8'h6F
`define TMR_T2CTRL_MASK   8'hFF
`define TMR_IRQEN_MASK    8'hFF
`define TMR_CTRL_OVF1     7
`define TMR_CTRL_RUN1     6
`define TMR_CTRL_OVF0     5
`define TMR_CTRL_RUN0     4
`define TMR_CTRL_EIRQ1    3
`define TMR_CTRL_ETRG1    2
`define TMR_CTRL_EIRQ0    1
`define TMR_CTRL_ETRG0    0
`define TMR_MODE_GATE1    7
`define TMR_MODE_CSEL1    6
`define TMR_MODE_GATE0    3
`define TMR_MODE_CSEL0    2
`define TMR_OPT_SRC1      6
`define TMR_OPT_SRC0      5
`define TMR_OPT_PRE1      3
`define TMR_OPT_PRE0      2
`define TMR_OPT_CMP1      1
`define TMR_OPT_CMP0      0
`define TMR_T2_OVF        7
`define TMR_T2_EXF        6
`define TMR_T2_RXCLK      5
`define TMR_T2_TXCLK      4
`define TMR_T2_RUN        2
`define TMR_T2_CSEL       1
`define TMR_T2_CPRL       0
`define TMR_IRQEN_T2      5
`define TMR_PRESCALE_DIV  12
`define TMR_SYS_HZ        125000000
`define TMR_SLOW_HZ       32768
`define TMR_SLOW_HALF     (`TMR_SYS_HZ / (2 * `TMR_SLOW_HZ))
`endif

// File: rtl/dual_timer_pkg.sv
// types shared by the dual timer design
package dual_timer_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } timer_mode_e;
    typedef enum logic [1:0] {
        T2_CAPTURE = 2'b00,
        T2_RELOAD  = 2'b01,
        T2_BAUD    = 2'b11,
        T2_CLKOUT  = 2'b10
    } t2_mode_e;
    typedef struct packed {
        logic [7:0] dat;
        logic [7:0] adr;
        logic       we;
        logic       sel;
        logic       cyc;
        logic       stb;
    } wb_req_s;
    typedef struct packed {
        logic       gate;
        logic       csel;
        logic [1:0] mode;
    } timer_cfg_s;
endpackage

// File: rtl/dual_timer_counter_regs.sv
// two classic timer/counters plus a timer2 count, behind a wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"
module dual_timer_counter_regs #(
    parameter int PRESCALE_DIV = `TMR_PRESCALE_DIV,
    parameter int SLOW_HALF    = `TMR_SLOW_HALF
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // wishbone slave
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [7:0] adr_i,
    input  wire logic [3:0] sel_i,
    input  wire logic [7:0] dat_i,
    output logic      [7:0] dat_o,
    output logic            ack_o,
    // external pins
    input  wire logic       ext_irq0_pin_i,
    input  wire logic       ext_irq1_pin_i,
    input  wire logic       timer0_pin_i,
    input  wire logic       timer1_pin_i,
    input  wire logic       timer2_pin_i,
    output logic            timer0_pin_o,
    output logic            timer0_pin_oe_o,
    output logic            timer1_pin_o,
    output logic            timer1_pin_oe_o,
    // interrupt requests and timer1 overflow
    output logic            timer0_irq_o,
    output logic            timer1_irq_o,
    output logic            timer2_irq_o,
    output logic            timer1_overflow_o
);
    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] opt_reg;
    logic [7:0] t0l_reg, t0h_reg, t1l_reg, t1h_reg;
    logic [7:0] t2l_reg, t2h_reg, t2ctrl_reg, irqen_reg;
    logic [7:0] dat_next;

    dual_timer_pkg::wb_req_s    req;
    dual_timer_pkg::timer_cfg_s cfg0, cfg1;
    dual_timer_pkg::t2_mode_e   t2_mode;

    assign req  = '{dat: dat_i, adr: adr_i, we: we_i, sel: sel_i[0],
                    cyc: cyc_i, stb: stb_i};
    assign cfg0 = '{gate: mode_reg[`TMR_MODE_GATE0],
                    csel: mode_reg[`TMR_MODE_CSEL0], mode: mode_reg[1:0]};
    assign cfg1 = '{gate: mode_reg[`TMR_MODE_GATE1],
                    csel: mode_reg[`TMR_MODE_CSEL1], mode: mode_reg[5:4]};

    // write strobe: one per access, on the cycle ack rises
    logic wr_en;
    assign wr_en = req.cyc && req.stb && req.we && req.sel && !ack_o;

    function automatic logic wr_hit(input logic [7:0] ofs);
        return wr_en && (req.adr == ofs);
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // three stages; a change counts once stages two and three agree
    logic [4:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 5'h1F;
            sync2_reg <= 5'h1F;
            sync3_reg <= 5'h1F;
            pin_reg   <= 5'h1F;
        end else begin
            sync1_reg <= {timer2_pin_i, timer1_pin_i, timer0_pin_i,
                          ext_irq1_pin_i, ext_irq0_pin_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 5; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end
    logic [4:0] pin_last_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_last_reg <= 5'h1F;
        end else begin
            pin_last_reg <= pin_reg;
        end
    end
    logic [4:0] pin_fall;
    assign pin_fall = pin_last_reg & ~pin_reg;

    // ****************************************************************
    // time bases
    // ****************************************************************
    logic [3:0]  pre_cnt_reg;
    logic        pre_tick;
    logic [15:0] slow_cnt_reg;
    logic        slow_clk_reg, slow_last_reg;
    logic        slow_tick;
    assign pre_tick = (pre_cnt_reg == 4'(PRESCALE_DIV - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i || pre_tick) begin
            pre_cnt_reg <= 4'h0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
        end
    end
    // slow 32.768kHz tick, approximated from the system clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_cnt_reg  <= 16'h0000;
            slow_clk_reg  <= 1'b0;
            slow_last_reg <= 1'b0;
        end else begin
            slow_last_reg <= slow_clk_reg;
            if (slow_cnt_reg == 16'(SLOW_HALF - 1)) begin
                slow_cnt_reg <= 16'h0000;
                slow_clk_reg <= ~slow_clk_reg;
            end else begin
                slow_cnt_reg <= slow_cnt_reg + 16'h0001;
            end
        end
    end
    assign slow_tick = slow_clk_reg && !slow_last_reg;

    // timer tick: source, then prescale selection
    function automatic logic timer_tick(input logic src, input logic pre);
        if (src) begin
            return slow_tick;
        end
        return pre ? 1'b1 : pre_tick;
    endfunction

    // ****************************************************************
    // count enables
    // ****************************************************************
    logic split;
    logic en0, en1, en0h;
    assign split = (cfg0.mode == dual_timer_pkg::MODE_SPLIT);
    assign en0 = ctrl_reg[`TMR_CTRL_RUN0]
               && (!cfg0.gate || pin_reg[0])
               && (cfg0.csel ? pin_fall[2]
                   : timer_tick(opt_reg[`TMR_OPT_SRC0],
                                opt_reg[`TMR_OPT_PRE0]));
    assign en0h = split && ctrl_reg[`TMR_CTRL_RUN1]
               && timer_tick(opt_reg[`TMR_OPT_SRC0], opt_reg[`TMR_OPT_PRE0]);
    // timer1 runs by its mode alone while timer0 is split
    assign en1 = split
        ? (cfg1.mode != dual_timer_pkg::MODE_SPLIT)
          && timer_tick(opt_reg[`TMR_OPT_SRC1], opt_reg[`TMR_OPT_PRE1])
        : ctrl_reg[`TMR_CTRL_RUN1]
          && (!cfg1.gate || pin_reg[1])
          && (cfg1.csel ? pin_fall[3]
              : timer_tick(opt_reg[`TMR_OPT_SRC1],
                           opt_reg[`TMR_OPT_PRE1]));

    // ****************************************************************
    // counter step shared by both timers
    // ****************************************************************
    // returns {overflow, high, low}
    function automatic logic [16:0] step(input logic [1:0] md,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13 = 14'h0000;
        c16 = 17'h00000;
        c8  = 9'h000;
        case (md)
            2'b00: begin
                c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
                return {c13[13], c13[12:5], lo[7:5], c13[4:0]};
            end
            2'b01: begin
                c16 = {1'b0, hi, lo} + 17'h00001;
                return c16;
            end
            2'b10: begin
                c8 = {1'b0, lo} + 9'h001;
                return {c8[8], hi, c8[8] ? hi : c8[7:0]};
            end
            default: begin
                c8 = {1'b0, lo} + 9'h001;
                return {c8[8], hi, c8[7:0]};
            end
        endcase
    endfunction

    logic [16:0] s0, s1;
    logic [8:0]  s0h;
    logic        ovf0, ovf0h, ovf1;
    assign s0    = step(cfg0.mode, t0l_reg, t0h_reg);
    assign s1    = step((cfg1.mode == dual_timer_pkg::MODE_SPLIT)
                        ? dual_timer_pkg::MODE_16BIT : cfg1.mode,
                        t1l_reg, t1h_reg);
    assign s0h   = {1'b0, t0h_reg} + 9'h001;
    assign ovf0  = en0 && s0[16];
    assign ovf0h = en0h && s0h[8];
    assign ovf1  = en1 && s1[16];

    // ****************************************************************
    // count registers
    // ****************************************************************
    // byte access; a write wins over a count in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t0l_reg <= `TMR_RESET_VAL;
            t0h_reg <= `TMR_RESET_VAL;
        end else begin
            if (en0) begin
                t0l_reg <= s0[7:0];
                if (!split) begin
                    t0h_reg <= s0[15:8];
                end
            end
            if (en0h) begin
                t0h_reg <= s0h[7:0];
            end
            if (wr_hit(`TMR_OFS_T0L)) begin
                t0l_reg <= req.dat;
            end
            if (wr_hit(`TMR_OFS_T0H)) begin
                t0h_reg <= req.dat;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t1l_reg <= `TMR_RESET_VAL;
            t1h_reg <= `TMR_RESET_VAL;
        end else begin
            if (en1) begin
                t1l_reg <= s1[7:0];
                t1h_reg <= s1[15:8];
            end
            if (wr_hit(`TMR_OFS_T1L)) begin
                t1l_reg <= req.dat;
            end
            if (wr_hit(`TMR_OFS_T1H)) begin
                t1h_reg <= req.dat;
            end
        end
    end

    // ****************************************************************
    // control, mode and option registers
    // ****************************************************************
    logic set0, set1;
    assign set0 = ovf0;
    // timer1 flag from split high byte
    assign set1 = split ? ovf0h : ovf1;
    // hardware set wins over software clear
    // external irq bits stored as written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `TMR_RESET_VAL;
        end else begin
            if (wr_hit(`TMR_OFS_CTRL)) begin
                ctrl_reg <= req.dat;
            end
            if (set0) begin
                ctrl_reg[`TMR_CTRL_OVF0] <= 1'b1;
            end
            if (set1) begin
                ctrl_reg[`TMR_CTRL_OVF1] <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg   <= `TMR_RESET_VAL;
            opt_reg    <= `TMR_RESET_VAL;
            irqen_reg  <= `TMR_RESET_VAL;
        end else begin
            if (wr_hit(`TMR_OFS_MODE)) begin
                mode_reg <= req.dat;
            end
            if (wr_hit(`TMR_OFS_CLKOPT)) begin
                opt_reg <= req.dat & `TMR_CLKOPT_MASK;
            end
            if (wr_hit(`TMR_OFS_IRQEN)) begin
                irqen_reg <= req.dat;
            end
        end
    end

    // ****************************************************************
    // timer2 count
    // ****************************************************************
    // mode from receive, transmit and capture/reload bits
    always_comb begin
        if (t2ctrl_reg[`TMR_T2_RXCLK] || t2ctrl_reg[`TMR_T2_TXCLK]) begin
            t2_mode = dual_timer_pkg::T2_BAUD;
        end else if (t2ctrl_reg[`TMR_T2_CPRL]) begin
            t2_mode = dual_timer_pkg::T2_CAPTURE;
        end else begin
            t2_mode = dual_timer_pkg::T2_RELOAD;
        end
    end
    logic        en2;
    logic [16:0] s2;
    assign en2 = t2ctrl_reg[`TMR_T2_RUN]
               && (t2ctrl_reg[`TMR_T2_CSEL] ? pin_fall[4] : 1'b1);
    assign s2  = {1'b0, t2h_reg, t2l_reg} + 17'h00001;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t2l_reg <= `TMR_RESET_VAL;
            t2h_reg <= `TMR_RESET_VAL;
        end else begin
            if (en2) begin
                t2l_reg <= s2[7:0];
                t2h_reg <= s2[15:8];
            end
            if (wr_hit(`TMR_OFS_T2L)) begin
                t2l_reg <= req.dat;
            end
            if (wr_hit(`TMR_OFS_T2H)) begin
                t2h_reg <= req.dat;
            end
        end
    end
    // overflow flag in capture and reload modes; baud overflows raise none
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t2ctrl_reg <= `TMR_RESET_VAL;
        end else begin
            if (wr_hit(`TMR_OFS_T2CTRL)) begin
                t2ctrl_reg <= req.dat & `TMR_T2CTRL_MASK;
            end
            if (en2 && s2[16] && t2_mode != dual_timer_pkg::T2_BAUD) begin
                t2ctrl_reg[`TMR_T2_OVF] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // pin outputs and interrupt requests
    // ****************************************************************
    // compare toggles pin in timer mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer0_pin_o    <= 1'b0;
            timer0_pin_oe_o <= 1'b0;
            timer1_pin_o    <= 1'b0;
            timer1_pin_oe_o <= 1'b0;
        end else begin
            timer0_pin_oe_o <= opt_reg[`TMR_OPT_CMP0] && !cfg0.csel;
            timer1_pin_oe_o <= opt_reg[`TMR_OPT_CMP1] && !cfg1.csel;
            if (ovf0 && opt_reg[`TMR_OPT_CMP0] && !cfg0.csel) begin
                timer0_pin_o <= ~timer0_pin_o;
            end
            if (ovf1 && opt_reg[`TMR_OPT_CMP1] && !cfg1.csel) begin
                timer1_pin_o <= ~timer1_pin_o;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer0_irq_o      <= 1'b0;
            timer1_irq_o      <= 1'b0;
            timer2_irq_o      <= 1'b0;
            timer1_overflow_o <= 1'b0;
        end else begin
            timer0_irq_o      <= ctrl_reg[`TMR_CTRL_OVF0];
            timer1_irq_o      <= ctrl_reg[`TMR_CTRL_OVF1];
            timer2_irq_o      <= irqen_reg[`TMR_IRQEN_T2]
                              && (t2ctrl_reg[`TMR_T2_OVF]
                                  || t2ctrl_reg[`TMR_T2_EXF]);
            timer1_overflow_o <= ovf1; // baud source even when split
        end
    end

    // ****************************************************************
    // wishbone read and acknowledge
    // ****************************************************************
    // unmapped offsets read zero and still acknowledge
    always_comb begin
        case (req.adr)
            `TMR_OFS_CTRL:   dat_next = ctrl_reg;
            `TMR_OFS_MODE:   dat_next = mode_reg;
            `TMR_OFS_T0L:    dat_next = t0l_reg;
            `TMR_OFS_T1L:    dat_next = t1l_reg;
            `TMR_OFS_T0H:    dat_next = t0h_reg;
            `TMR_OFS_T1H:    dat_next = t1h_reg;
            `TMR_OFS_CLKOPT: dat_next = opt_reg;
            `TMR_OFS_T2L:    dat_next = t2l_reg;
            `TMR_OFS_T2H:    dat_next = t2h_reg;
            `TMR_OFS_T2CTRL: dat_next = t2ctrl_reg;
            `TMR_OFS_IRQEN:  dat_next = irqen_reg;
            default:         dat_next = 8'h00;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 8'h00;
        end else begin
            ack_o <= req.cyc && req.stb && !ack_o;
            dat_o <= dat_next;
        end
    end
endmodule // dual_timer_counter_regs

// File: verif/dual_timer_counter_regs_properties.sv
// port relations of the dual timer, attached by bind
`timescale 1ns/1ps
module dual_timer_counter_regs_properties (
    // clock, reset and bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       we_i,
    input wire logic [7:0] adr_i,
    input wire logic [7:0] dat_o,
    input wire logic       ack_o,
    // timer0 outputs
    input wire logic       timer0_pin_o,
    input wire logic       timer0_pin_oe_o,
    input wire logic       timer0_irq_o
);
    // one domain, so one clock and one disable
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack not one cycle after request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_unmapped;
        cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'h50
            |=> dat_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rst_out;
        $fell(rst_i) |-> !ack_o && !timer0_irq_o && !timer0_pin_oe_o;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("output active after reset");
    property p_pin_drv;
        $changed(timer0_pin_o) |-> timer0_pin_oe_o || $past(timer0_pin_oe_o);
    endproperty
    a_pin_drv: assert property (p_pin_drv)
        else $error("pin toggled while not driven");
    property p_tog_flag;
        $changed(timer0_pin_o) && timer0_pin_oe_o |-> ##[0:2] timer0_irq_o;
    endproperty
    a_tog_flag: assert property (p_tog_flag)
        else $error("toggle without overflow flag");
    property p_oe_wr;
        $rose(timer0_pin_oe_o) |-> ack_o && we_i || $past(ack_o && we_i);
    endproperty
    a_oe_wr: assert property (p_oe_wr)
        else $error("pin enable without a write");
endmodule // dual_timer_counter_regs_properties

bind dual_timer_counter_regs dual_timer_counter_regs_properties u_props (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
    .timer0_pin_o, .timer0_pin_oe_o, .timer0_irq_o
);

// File: verif/dual_timer_pin_model.sv
// count pin source: a burst of falling edges, idle high between bursts
`timescale 1ns/1ps
module dual_timer_pin_model (
    // clock and command
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [3:0] n_i,
    // pin and status
    output logic            cnt_o,
    output logic            busy_o
);
    logic [3:0] left_reg;
    logic [2:0] ph_reg;
    // slow 16-cycle period so each level outlasts the synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_o    <= 1'b1;
            left_reg <= 4'h0;
            ph_reg   <= 3'h0;
        end else if (go_i) begin
            left_reg <= n_i;
            ph_reg   <= 3'h0;
        end else if (left_reg != 4'h0) begin
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == 3'h7) begin
                cnt_o <= ~cnt_o;
                if (!cnt_o) left_reg <= left_reg - 4'h1;
            end
        end
    end
    assign busy_o = left_reg != 4'h0;
endmodule // dual_timer_pin_model

// File: verif/dual_timer_counter_regs_tb.sv
// self-checking bench of the dual timer registers and counting
`timescale 1ns/1ps
module dual_timer_counter_regs_tb;
    logic       clk_i, rst_i, cyc_i, stb_i, we_i, gate0, go;
    logic [7:0] adr_i, dat_i, q;
    logic [3:0] sel_i, npulse;
    logic [7:0] dat_o;
    logic       ack_o, t0o, t0oe, irq0, irq1, irq2, pin0, busy;
    logic       t1oe, t1ov;
    int         n_errors, tests_run;
    dual_timer_counter_regs #(.PRESCALE_DIV(12), .SLOW_HALF(2)) dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .ext_irq0_pin_i(gate0), .ext_irq1_pin_i(1'b1),
        .timer0_pin_i(pin0), .timer1_pin_i(1'b1), .timer2_pin_i(1'b1),
        .timer0_pin_o(t0o), .timer0_pin_oe_o(t0oe), .timer1_pin_o(),
        .timer1_pin_oe_o(t1oe), .timer0_irq_o(irq0), .timer1_irq_o(irq1),
        .timer2_irq_o(irq2), .timer1_overflow_o(t1ov));
    dual_timer_pin_model pm (.clk_i, .rst_i, .go_i(go), .n_i(npulse),
        .cnt_o(pin0), .busy_o(busy));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h", $time, m, g);
        end
    endtask
    // classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, d, input logic s);
        int i;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        sel_i <= {3'h0, s};
        for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        wb(1'b1, a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, e, string m);
        wb(1'b0, a, 8'h00, 1'b1);
        chk(q, e, m);
    endtask
    function automatic logic sig(int k);
        return k == 0 ? irq0 : k == 1 ? irq1 : k == 2 ? t0o
             : k == 3 ? !busy : t1ov;
    endfunction
    // bounded wait on an output; running out ends the run
    task automatic wait_for(input int k);
        int i;
        for (i = 0; i < 300 && sig(k) !== 1'b1; i++) @(posedge clk_i);
        if (i == 300) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic pulse(input logic [3:0] n);
        {go, npulse} <= {1'b1, n};
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        wait_for(3);
    endtask
    task automatic t_regs();
        logic [7:0] a [7] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCE};
        foreach (a[j]) rd(a[j], 8'h00, "reset value");
        for (int j = 2; j < 6; j++) begin
            wr(a[j], 8'hA5);
            rd(a[j], 8'hA5, "count byte");
        end
        wr(8'hCE, 8'hFF);
        rd(8'hCE, 8'h6F, "options reserved bits");
        chk({7'h0, t1oe}, 8'h01, "t1 pin driven");
        wb(1'b1, 8'h8A, 8'h3C, 1'b0);
        rd(8'h8A, 8'hA5, "write without select");
        wr(8'h50, 8'hFF);
        rd(8'h50, 8'h00, "unmapped");
        wr(8'h88, 8'h0F);
        rd(8'h88, 8'h0F, "ext irq bits");
        wr(8'h88, 8'h20);
        wait_for(0);
        wr(8'h88, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq0}, 8'h00, "flag clear");
        $display("test regs done");
    endtask
    task automatic t_mode0();
        wr(8'h89, 8'h00);
        wr(8'hCE, 8'h04);
        wr(8'h8A, 8'hFF);
        wr(8'h8C, 8'hFF);
        wr(8'h88, 8'h10);
        wait_for(0);
        wr(8'h88, 8'h00);
        rd(8'h8C, 8'h00, "13-bit wrap");
        wb(1'b0, 8'h8A, 8'h00, 1'b1);
        chk({5'h0, q[7:5]}, 8'h07, "low top bits kept");
        chk({7'h0, q[4:0] < 5'h08}, 8'h01, "low bits wrapped");
        $display("test mode0 done");
    endtask
    task automatic t_reload();
        wr(8'h89, 8'h20);
        wr(8'hCE, 8'h08);
        wr(8'h8D, 8'hF0);
        wr(8'h8B, 8'hFE);
        wr(8'h88, 8'h40);
        wait_for(4);
        wait_for(1);
        wr(8'h88, 8'h00);
        rd(8'h8D, 8'hF0, "reload byte kept");
        wb(1'b0, 8'h8B, 8'h00, 1'b1);
        chk({7'h0, q >= 8'hF0}, 8'h01, "low byte reloaded");
        $display("test reload done");
    endtask
    task automatic t_counter();
        wr(8'h89, 8'h0D);
        wr(8'h8A, 8'h00);
        gate0 <= 1'b1;
        wr(8'h88, 8'h10);
        pulse(4'h3);
        rd(8'h8A, 8'h03, "pin edges");
        chk({7'h0, t0oe}, 8'h00, "pin left as input");
        gate0 <= 1'b0;
        pulse(4'h2);
        rd(8'h8A, 8'h03, "gate low");
        wr(8'h89, 8'h05);
        pulse(4'h1);
        rd(8'h8A, 8'h04, "gate off");
        wr(8'h88, 8'h00);
        pulse(4'h2);
        rd(8'h8A, 8'h04, "stopped");
        $display("test counter done");
    endtask
    task automatic t_compare();
        wr(8'h89, 8'h01);
        wr(8'hCE, 8'h05);
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'hFF);
        chk({7'h0, t0oe}, 8'h01, "pin driven");
        wr(8'h88, 8'h10);
        wait_for(2);
        wait_for(0);
        wr(8'h88, 8'h00);
        wr(8'hCE, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({7'h0, t0oe}, 8'h00, "pin released");
        $display("test compare done");
    endtask
    // divide by twelve, then the slow source with a four-cycle period
    task automatic t_prescale();
        logic [7:0] lo [2] = '{8'h08, 8'h18};
        foreach (lo[j]) begin
            wr(8'hCE, j ? 8'h20 : 8'h00);
            wr(8'h8A, 8'h00);
            wr(8'h8C, 8'h00);
            wr(8'h88, 8'h10);
            repeat (96) @(posedge clk_i);
            wr(8'h88, 8'h00);
            wb(1'b0, 8'h8A, 8'h00, 1'b1);
            chk({7'h0, q - lo[j] < 8'h02}, 8'h01, "rate");
        end
        $display("test prescale done");
    endtask
    task automatic t_split();
        wr(8'h89, 8'h03);
        wr(8'hCE, 8'h04);
        wr(8'h8A, 8'h33);
        wr(8'h8C, 8'hFE);
        wr(8'h88, 8'h40);
        wait_for(1);
        chk({7'h0, irq0}, 8'h00, "split low idle");
        wr(8'h88, 8'h00);
        rd(8'h8A, 8'h33, "split low held");
        $display("test split done");
    endtask
    task automatic t_timer2();
        wr(8'hCC, 8'h5A);
        wr(8'hC8, 8'h80);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq2}, 8'h00, "t2 irq masked");
        wr(8'hA8, 8'h20);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq2}, 8'h01, "t2 irq enabled");
        rd(8'hCC, 8'h5A, "t2 low held");
        wr(8'hC8, 8'h04);
        wr(8'hC8, 8'h00);
        wb(1'b0, 8'hCC, 8'h00, 1'b1);
        chk({7'h0, q > 8'h5A && q < 8'h62}, 8'h01, "t2 counts");
        $display("test timer2 done");
    endtask
    // reset for eight cycles, then each scenario in turn
    initial begin
        {rst_i, cyc_i, stb_i, we_i, gate0, go} = 6'b100010;
        {adr_i, dat_i, sel_i, npulse} = 24'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mode0();
        t_reload();
        t_counter();
        t_compare();
        t_prescale();
        t_split();
        t_timer2();
        stop_test();
    end
endmodule // dual_timer_counter_regs_tb
